// ---- logic/tfam_cmd_decode.sv ----
`default_nettype none
module tfam_cmd_decode
  import tfam_pkg::*;
(
  input wire logic [7:0] cmd_in,
  input wire logic [7:0] fn_in,
  output logic known_out,
  output logic is_write_out,
  output logic is_masked_out,
  output logic three_fields_out
);
  always_comb begin
    known_out = 1'b0;
    is_write_out = 1'b0;
    is_masked_out = 1'b0;
    three_fields_out = 1'b0;
    if (cmd_in == TFAM_CMD_TYPED) begin // [R1]
      case (fn_in)
        TFAM_FN_RD2: begin
          known_out = 1'b1;
        end
        TFAM_FN_RD3: begin
          known_out = 1'b1;
          three_fields_out = 1'b1;
        end
        TFAM_FN_WR2: begin
          known_out = 1'b1;
          is_write_out = 1'b1;
        end
        TFAM_FN_WR3: begin
          known_out = 1'b1;
          is_write_out = 1'b1;
          three_fields_out = 1'b1;
        end
        TFAM_FN_WRM: begin
          known_out = 1'b1;
          is_write_out = 1'b1;
          is_masked_out = 1'b1;
          three_fields_out = 1'b1;
        end
        default: begin
          known_out = 1'b0;
        end
      endcase
    end
  end
endmodule : tfam_cmd_decode
`default_nettype wire

// ---- logic/tfam_mapper.sv ----
// Notes on behaviour
// [R1] command byte 0x0F with function 0xA1/0xA2 reads, 0xA9/0xAA writes, 0xAB masked write.
// [R2] each request carries the module-side part first and the remote-node part second.
// [R3] each file is a 200-word window overlaying consecutive database words, no own storage.
// [R4] the mapping follows the first-file and words-per-file settings, defaults 7 and 200.
// [R5] file F element E maps to word (F - first) * size + E.
// [R6] every word is classed into user, backplane, port setup, commands, status, control, reserved.
// [R7] all regions, configuration and status included, are readable and writable.
// [R8] a file below the first file or a word past the end is refused with an error, no access.
`default_nettype none
module tfam_mapper
  import tfam_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  // settings, held stable while requests run
  input wire logic [7:0] cfg_first_file_in,
  input wire logic [15:0] cfg_file_size_in,
  // request
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [7:0] req_cmd_in,
  input wire logic [7:0] req_fn_in,
  input wire logic [15:0] req_wdata_in,
  input wire logic [15:0] req_mask_in,
  input wire logic [7:0] req_node_in,
  input wire logic [7:0] req_file_in,
  input wire logic [7:0] req_elem_in,
  // database port, one-cycle read latency
  output logic db_en_out,
  output logic db_we_out,
  output logic [13:0] db_addr_out,
  output logic [15:0] db_wdata_out,
  input wire logic [15:0] db_rdata_in,
  // response
  output logic resp_valid_out,
  output logic resp_error_out,
  output logic [1:0] resp_err_code_out,
  output logic resp_is_write_out,
  output logic [15:0] resp_data_out,
  output logic [13:0] resp_index_out,
  output logic [2:0] resp_region_out,
  output logic [7:0] resp_node_out
);
  function automatic logic [24:0] tfam_word_index(input logic [7:0] file, input logic [7:0] first,
                                                  input logic [7:0] elem, input logic [15:0] size);
    logic [7:0] diff;
    logic [23:0] prod;
    diff = file - first;
    prod = 24'(diff) * 24'(size);
    return 25'(prod) + 25'(elem);
  endfunction : tfam_word_index

  function automatic tfam_region_t tfam_region_of(input logic [13:0] word);
    tfam_region_t rg;
    if (word < TFAM_RG_BACKPLANE) begin
      rg = TFAM_REGION_USER;
    end else if (word < TFAM_RG_PORT_SETUP) begin
      rg = TFAM_REGION_BACKPLANE;
    end else if (word < TFAM_RG_RSVD_LOW) begin
      rg = TFAM_REGION_PORT_SETUP;
    end else if (word < TFAM_RG_COMMANDS) begin
      rg = TFAM_REGION_RESERVED;
    end else if (word < TFAM_RG_STATUS) begin
      rg = TFAM_REGION_COMMANDS;
    end else if (word < TFAM_RG_CMD_CTRL) begin
      rg = TFAM_REGION_STATUS;
    end else if (word < TFAM_RG_RSVD_HIGH) begin
      rg = TFAM_REGION_CMD_CTRL;
    end else begin
      rg = TFAM_REGION_RESERVED;
    end
    return rg;
  endfunction : tfam_region_of

  // reset release through two flops
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  logic dec_known;
  logic dec_write;
  logic dec_masked;
  logic dec_three;
  tfam_cmd_decode u_decode (
    .cmd_in(req_cmd_in),
    .fn_in(req_fn_in),
    .known_out(dec_known),
    .is_write_out(dec_write),
    .is_masked_out(dec_masked),
    .three_fields_out(dec_three)
  );

  // three-field forms name a sub-element; on word files it selects nothing more
  logic [24:0] idx_full;
  logic below;
  logic beyond;
  assign idx_full = tfam_word_index(req_file_in, cfg_first_file_in,
                                    req_elem_in, cfg_file_size_in); // [R4] [R5]
  assign below = req_file_in < cfg_first_file_in; // [R8]
  assign beyond = idx_full > 25'(TFAM_DB_LAST); // [R8]

  tfam_state_t state_r, state_nxt;
  logic ready_r, ready_nxt;
  logic db_en_r, db_en_nxt;
  logic db_we_r, db_we_nxt;
  logic [13:0] db_addr_r, db_addr_nxt;
  logic [15:0] db_wdata_r, db_wdata_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic masked_r, masked_nxt;
  logic resp_valid_r, resp_valid_nxt;
  logic resp_error_r, resp_error_nxt;
  tfam_err_t resp_code_r, resp_code_nxt;
  logic resp_write_r, resp_write_nxt;
  logic [15:0] resp_data_r, resp_data_nxt;
  logic [13:0] resp_index_r, resp_index_nxt;
  tfam_region_t resp_region_r, resp_region_nxt;
  logic [7:0] resp_node_r, resp_node_nxt;

  always_comb begin
    state_nxt = state_r;
    db_en_nxt = 1'b0;
    db_we_nxt = 1'b0;
    db_addr_nxt = db_addr_r;
    db_wdata_nxt = db_wdata_r;
    mask_nxt = mask_r;
    masked_nxt = masked_r;
    resp_valid_nxt = 1'b0;
    resp_error_nxt = resp_error_r;
    resp_code_nxt = resp_code_r;
    resp_write_nxt = resp_write_r;
    resp_data_nxt = resp_data_r;
    resp_index_nxt = resp_index_r;
    resp_region_nxt = resp_region_r;
    resp_node_nxt = resp_node_r;
    case (state_r)
      TFAM_ST_IDLE: begin
        if (req_valid_in && ready_r) begin
          // module-side result fields first, remote-node echo kept apart
          resp_index_nxt = idx_full[13:0]; // [R2]
          resp_node_nxt = req_node_in; // [R2]
          resp_write_nxt = dec_write;
          resp_data_nxt = TFAM_WORD_RST;
          resp_region_nxt = tfam_region_of(idx_full[13:0]); // [R6]
          db_addr_nxt = idx_full[13:0]; // [R3]
          db_wdata_nxt = req_wdata_in;
          mask_nxt = req_mask_in;
          masked_nxt = dec_masked;
          if (!dec_known) begin // [R1]
            resp_error_nxt = 1'b1;
            resp_code_nxt = TFAM_ERR_CMD;
            state_nxt = TFAM_ST_RESP;
          end else if (below) begin // [R8]
            resp_error_nxt = 1'b1;
            resp_code_nxt = TFAM_ERR_BELOW;
            state_nxt = TFAM_ST_RESP;
          end else if (beyond) begin // [R8]
            resp_error_nxt = 1'b1;
            resp_code_nxt = TFAM_ERR_BEYOND;
            state_nxt = TFAM_ST_RESP;
          end else begin
            // no region is write-protected: remote setup and status access by design
            resp_error_nxt = 1'b0; // [R7]
            resp_code_nxt = TFAM_ERR_NONE;
            db_en_nxt = 1'b1;
            if (dec_write && !dec_masked) begin
              db_we_nxt = 1'b1;
              state_nxt = TFAM_ST_WR;
            end else begin
              state_nxt = TFAM_ST_RD_ISSUE;
            end
          end
        end
      end
      TFAM_ST_RD_ISSUE: begin
        state_nxt = TFAM_ST_RD_TAKE;
      end
      TFAM_ST_RD_TAKE: begin
        resp_data_nxt = db_rdata_in;
        if (masked_r) begin
          // masked write merges against the old word, costing one read first
          db_wdata_nxt = (db_rdata_in & ~mask_r) | (db_wdata_r & mask_r); // [R1]
          db_en_nxt = 1'b1;
          db_we_nxt = 1'b1;
          state_nxt = TFAM_ST_WR;
        end else begin
          resp_valid_nxt = 1'b1;
          state_nxt = TFAM_ST_RESP;
        end
      end
      TFAM_ST_WR: begin
        resp_data_nxt = db_wdata_r;
        resp_valid_nxt = 1'b1;
        state_nxt = TFAM_ST_RESP;
      end
      TFAM_ST_RESP: begin
        // error path arrives here without a pulse yet
        resp_valid_nxt = !resp_valid_r;
        state_nxt = resp_valid_r ? TFAM_ST_IDLE : TFAM_ST_RESP;
      end
      default: begin
        state_nxt = TFAM_ST_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == TFAM_ST_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TFAM_ST_IDLE;
      ready_r <= 1'b0;
      db_en_r <= 1'b0;
      db_we_r <= 1'b0;
      db_addr_r <= TFAM_ADDR_RST;
      db_wdata_r <= TFAM_WORD_RST;
      mask_r <= TFAM_WORD_RST;
      masked_r <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_error_r <= 1'b0;
      resp_code_r <= TFAM_ERR_NONE;
      resp_write_r <= 1'b0;
      resp_data_r <= TFAM_WORD_RST;
      resp_index_r <= TFAM_ADDR_RST;
      resp_region_r <= TFAM_REGION_USER;
      resp_node_r <= TFAM_BYTE_RST;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      db_en_r <= db_en_nxt;
      db_we_r <= db_we_nxt;
      db_addr_r <= db_addr_nxt;
      db_wdata_r <= db_wdata_nxt;
      mask_r <= mask_nxt;
      masked_r <= masked_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_error_r <= resp_error_nxt;
      resp_code_r <= resp_code_nxt;
      resp_write_r <= resp_write_nxt;
      resp_data_r <= resp_data_nxt;
      resp_index_r <= resp_index_nxt;
      resp_region_r <= resp_region_nxt;
      resp_node_r <= resp_node_nxt;
    end
  end

  assign req_ready_out = ready_r;
  assign db_en_out = db_en_r;
  assign db_we_out = db_we_r;
  assign db_addr_out = db_addr_r;
  assign db_wdata_out = db_wdata_r;
  assign resp_valid_out = resp_valid_r;
  assign resp_error_out = resp_error_r;
  assign resp_err_code_out = resp_code_r;
  assign resp_is_write_out = resp_write_r;
  assign resp_data_out = resp_data_r;
  assign resp_index_out = resp_index_r;
  assign resp_region_out = resp_region_r;
  assign resp_node_out = resp_node_r;
endmodule : tfam_mapper
`default_nettype wire

// ---- logic/tfam_pkg.sv ----
`default_nettype none
package tfam_pkg;
  // typed logical command group and its function bytes
  localparam logic [7:0] TFAM_CMD_TYPED = 8'h0F;
  localparam logic [7:0] TFAM_FN_RD2 = 8'hA1;
  localparam logic [7:0] TFAM_FN_RD3 = 8'hA2;
  localparam logic [7:0] TFAM_FN_WR2 = 8'hA9;
  localparam logic [7:0] TFAM_FN_WR3 = 8'hAA;
  localparam logic [7:0] TFAM_FN_WRM = 8'hAB;
  // mapping defaults
  localparam logic [7:0] TFAM_DEF_FIRST_FILE = 8'h07;
  localparam logic [15:0] TFAM_DEF_FILE_SIZE = 16'h00C8;
  // database bounds and region starts, in words
  localparam logic [13:0] TFAM_DB_LAST = 14'h270F;
  localparam logic [13:0] TFAM_RG_BACKPLANE = 14'h1388;
  localparam logic [13:0] TFAM_RG_PORT_SETUP = 14'h1392;
  localparam logic [13:0] TFAM_RG_RSVD_LOW = 14'h13CE;
  localparam logic [13:0] TFAM_RG_COMMANDS = 14'h1450;
  localparam logic [13:0] TFAM_RG_STATUS = 14'h1DB0;
  localparam logic [13:0] TFAM_RG_CMD_CTRL = 14'h1E78;
  localparam logic [13:0] TFAM_RG_RSVD_HIGH = 14'h1F40;
  // reset values
  localparam logic [15:0] TFAM_WORD_RST = 16'h0000;
  localparam logic [13:0] TFAM_ADDR_RST = 14'h0000;
  localparam logic [7:0] TFAM_BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    TFAM_REGION_USER = 3'b000,
    TFAM_REGION_BACKPLANE = 3'b001,
    TFAM_REGION_PORT_SETUP = 3'b010,
    TFAM_REGION_RESERVED = 3'b011,
    TFAM_REGION_COMMANDS = 3'b100,
    TFAM_REGION_STATUS = 3'b101,
    TFAM_REGION_CMD_CTRL = 3'b110
  } tfam_region_t;

  typedef enum logic [1:0] {
    TFAM_ERR_NONE = 2'b00,
    TFAM_ERR_CMD = 2'b01,
    TFAM_ERR_BELOW = 2'b10,
    TFAM_ERR_BEYOND = 2'b11
  } tfam_err_t;

  typedef enum logic [2:0] {
    TFAM_ST_IDLE = 3'b000,
    TFAM_ST_RD_ISSUE = 3'b001,
    TFAM_ST_RD_TAKE = 3'b010,
    TFAM_ST_WR = 3'b011,
    TFAM_ST_RESP = 3'b100
  } tfam_state_t;
endpackage : tfam_pkg
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb
  import tfam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, rdy, en, we, rv, re, rw;
  logic [7:0] first = 8'h07, c = 8'h00, f = 8'h00, fl = 8'h00, el = 8'h00, nd = 8'h00, rn;
  logic [15:0] size = 16'h00C8, wd = 16'h0000, m = 16'h0000, dwd, drd, rdat;
  logic [13:0] addr, rix;
  logic [1:0] rcode;
  logic [15:0] shadow [0:16383];
  logic [7:0] fns [0:5] = '{8'hA1, 8'hA2, 8'hA9, 8'hAA, 8'hAB, 8'hA3};
  logic [31:0] r;
  int fail_count = 0, n_compared = 0, cyc = 0;
  integer seed = 32'h539A;
  tfam_mapper DUT (.clk_in(clk), .arst_n_in(rst_n), .cfg_first_file_in(first),
    .cfg_file_size_in(size), .req_valid_in(vld), .req_ready_out(rdy), .req_cmd_in(c),
    .req_fn_in(f), .req_wdata_in(wd), .req_mask_in(m), .req_node_in(nd), .req_file_in(fl),
    .req_elem_in(el), .db_en_out(en), .db_we_out(we), .db_addr_out(addr),
    .db_wdata_out(dwd), .db_rdata_in(drd), .resp_valid_out(rv), .resp_error_out(re),
    .resp_err_code_out(rcode), .resp_is_write_out(rw), .resp_data_out(rdat),
    .resp_index_out(rix), .resp_region_out(), .resp_node_out(rn));
  tfam_db_model u_db (.clk_in(clk), .en_in(en), .we_in(we), .addr_in(addr),
    .wdata_in(dwd), .rdata_out(drd));
  always #4 clk = ~clk;
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input logic [7:0] ci, fi, fli, eli, input logic [15:0] wdi, mi);
    int n, k, lat;
    logic [31:0] ix;
    logic [1:0] code;
    logic [15:0] ed;
    logic [7:0] en8;
    k = ci != TFAM_CMD_TYPED ? 0 : (fi == TFAM_FN_RD2 || fi == TFAM_FN_RD3) ? 1
      : (fi == TFAM_FN_WR2 || fi == TFAM_FN_WR3) ? 2 : fi == TFAM_FN_WRM ? 3 : 0;
    ix = {24'h0, fli - first} * {16'h0, size} + {24'h0, eli};
    code = k == 0 ? 2'h1 : fli < first ? 2'h2 : ix > 32'h0000270F ? 2'h3 : 2'h0;
    ed = code == 2'h0 && k != 2 ? shadow[ix[13:0]] : 16'h0000;
    if (code == 2'h0 && k >= 2) ed = k == 2 ? wdi : (ed & ~mi) | (wdi & mi);
    if (code == 2'h0 && k >= 2) shadow[ix[13:0]] = ed;
    lat = (code != 2'h0 || k == 2) ? 1 : k == 1 ? 2 : 3;
    en8 = 8'($random(seed));
    // request raised on an edge; ready is read settled, then the next edge takes it
    @(posedge clk);
    {c, f, fl, el, wd, m, nd} <= {ci, fi, fli, eli, wdi, mi, en8};
    vld <= 1'b1;
    #1;
    n = 0;
    while (rdy !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    vld <= 1'b0;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (rv !== 1'b1 && n < 10);
    chk(16'(n), 16'(lat));
    chk({14'h0, rcode}, {14'h0, code});
    chk({15'h0, re}, {15'h0, code != 2'h0});
    chk(rdat, ed);
    chk({8'h0, rn}, {8'h0, en8});
    if (code == 2'h0) begin
      chk({2'h0, rix}, ix[15:0]);
      chk({15'h0, rw}, {15'h0, k >= 2});
    end
  endtask : req
  initial begin
    for (int i = 0; i < 16384; i++) shadow[i] = 16'(i) ^ 16'h5A3C;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // hand-picked edges first: overlay examples, limits, refusals, back to back
    req(8'h0F, 8'hA1, 8'h08, 8'h00, 16'h0000, 16'h0000);
    req(8'h0F, 8'hA9, 8'h09, 8'h05, 16'h1234, 16'h0000);
    req(8'h0F, 8'hA2, 8'h09, 8'h05, 16'h0000, 16'h0000);
    req(8'h0F, 8'hAB, 8'h09, 8'h05, 16'hABCD, 16'h00FF);
    req(8'h0F, 8'hAA, 8'h38, 8'hC7, 16'hBEEF, 16'h0000);
    req(8'h0F, 8'hA2, 8'h39, 8'h00, 16'h0000, 16'h0000);
    req(8'h0F, 8'hA1, 8'h06, 8'h00, 16'h0000, 16'h0000);
    req(8'h0F, 8'hA3, 8'h08, 8'h00, 16'h0000, 16'h0000);
    req(8'h01, 8'hA1, 8'h08, 8'h00, 16'h0000, 16'h0000);
    req(8'h0F, 8'hA9, 8'h20, 8'h0A, 16'h5555, 16'h0000);
    for (int i = 0; i < 160; i++) begin
      if (i == 80) begin
        // settings only move while idle and under reset
        @(posedge clk);
        rst_n <= 1'b0;
        first <= 8'h0A;
        size <= 16'h0064;
        repeat (2) @(posedge clk);
        #1 chk({15'h0, rdy}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
      end
      r = $random(seed);
      req(r[3:0] == 4'h0 ? r[31:24] : 8'h0F, fns[r[6:4] % 6], 8'(r[13:8]), r[23:16],
        16'($random(seed)), r[31:16]);
    end
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

// ---- verif/tfam_db_model.sv ----
`default_nettype none
module tfam_db_model (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [13:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_r [0:16383];
  initial begin
    rdata_out = 16'h0000;
    for (int i = 0; i < 16384; i++) mem_r[i] = 16'(i) ^ 16'h5A3C;
  end
  // one store under every file window; data only valid the cycle after the strobe
  always @(posedge clk_in) begin
    if (en_in) begin
      rdata_out <= mem_r[addr_in];
      if (we_in) mem_r[addr_in] <= wdata_in;
    end else rdata_out <= ~rdata_out;
  end
endmodule : tfam_db_model
`default_nettype wire

// ---- verif/tfam_monitor.sv ----
`default_nettype none
module tfam_monitor
  import tfam_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] cfg_first_file_in,
  input wire logic [15:0] cfg_file_size_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic [7:0] req_cmd_in,
  input wire logic [7:0] req_fn_in,
  input wire logic [7:0] req_file_in,
  input wire logic [7:0] req_elem_in,
  input wire logic db_en_out,
  input wire logic db_we_out,
  input wire logic [13:0] db_addr_out,
  input wire logic resp_valid_out,
  input wire logic resp_error_out,
  input wire logic [1:0] resp_err_code_out,
  input wire logic [13:0] resp_index_out,
  input wire logic [2:0] resp_region_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic acc, rd, wr, wm, typed, below, good;
  logic [31:0] ix;
  logic [13:0] ixl;
  always_comb begin
    acc = req_valid_in && req_ready_out;
    rd = req_fn_in == TFAM_FN_RD2 || req_fn_in == TFAM_FN_RD3;
    wr = req_fn_in == TFAM_FN_WR2 || req_fn_in == TFAM_FN_WR3;
    wm = req_fn_in == TFAM_FN_WRM;
    typed = req_cmd_in == TFAM_CMD_TYPED && (rd || wr || wm);
    below = req_file_in < cfg_first_file_in;
    ix = {24'h0, req_file_in - cfg_first_file_in} * {16'h0, cfg_file_size_in}
      + {24'h0, req_elem_in};
    ixl = ix[13:0];
    good = typed && !below && ix <= {18'h0, TFAM_DB_LAST};
  end
  function automatic logic [2:0] reg_of(input logic [13:0] a);
    if (a < TFAM_RG_BACKPLANE) return TFAM_REGION_USER;
    if (a < TFAM_RG_PORT_SETUP) return TFAM_REGION_BACKPLANE;
    if (a < TFAM_RG_RSVD_LOW) return TFAM_REGION_PORT_SETUP;
    if (a < TFAM_RG_COMMANDS) return TFAM_REGION_RESERVED;
    if (a < TFAM_RG_STATUS) return TFAM_REGION_COMMANDS;
    if (a < TFAM_RG_CMD_CTRL) return TFAM_REGION_STATUS;
    if (a < TFAM_RG_RSVD_HIGH) return TFAM_REGION_CMD_CTRL;
    return TFAM_REGION_RESERVED;
  endfunction : reg_of
  sequence rd_s;
    db_en_out && !db_we_out && db_addr_out == $past(ixl);
  endsequence
  busy_then_ready_a: assert property (acc |=> !req_ready_out [*2] ##[0:3] req_ready_out)
    else $error("ready not dropped and restored around a request");
  bad_cmd_a: assert property (acc && !typed |=> !db_en_out ##1 resp_valid_out
    && resp_err_code_out == TFAM_ERR_CMD) else $error("unknown command not refused");
  read_map_a: assert property (acc && good && rd |=> rd_s ##1 !db_en_out ##1
    resp_valid_out && !resp_error_out) else $error("read access wrong");
  write_map_a: assert property (acc && good && wr |=> db_en_out && db_we_out
    && db_addr_out == $past(ixl) ##1 resp_valid_out) else $error("write access wrong");
  masked_seq_a: assert property (acc && good && wm |=> rd_s ##1 !db_en_out ##1
    db_en_out && db_we_out && db_addr_out == $past(db_addr_out, 2) ##1 resp_valid_out)
    else $error("masked write steps wrong");
  below_first_a: assert property (acc && typed && below |=> !db_en_out ##1
    resp_valid_out && resp_err_code_out == TFAM_ERR_BELOW) else $error("low file taken");
  past_end_a: assert property (acc && typed && !below && !good |=> !db_en_out ##1
    resp_valid_out && resp_err_code_out == TFAM_ERR_BEYOND) else $error("end overrun taken");
  resp_pulse_a: assert property (resp_valid_out |=> !resp_valid_out)
    else $error("response longer than one cycle");
  region_class_a: assert property (resp_valid_out && !resp_error_out |->
    resp_region_out == reg_of(resp_index_out)) else $error("region class wrong");
endmodule : tfam_monitor
bind tfam_mapper tfam_monitor u_mon (.clk_in, .arst_n_in, .cfg_first_file_in,
  .cfg_file_size_in, .req_valid_in, .req_ready_out, .req_cmd_in, .req_fn_in, .req_file_in,
  .req_elem_in, .db_en_out, .db_we_out, .db_addr_out, .resp_valid_out, .resp_error_out,
  .resp_err_code_out, .resp_index_out, .resp_region_out);
`default_nettype wire
